/* hw/acpi_dual_rail_sequencer.sv */
// sleep-state decoder, soft-start sequencer and fault logic of a dual-rail controller
// comparator results arrive as asynchronous levels; RESETN is the bias power-on reset
`timescale 1ns/100ps
`include "seq_cfg.svh"
// How it works
// RULE1 - active or S3: both dual outputs on
// RULE2 - soft-off: 3.3V on, 5V per variant
// RULE3 - illegal pin pair holds previous state
// RULE4 - no direct S3 to soft-off moves
// RULE5 - filter sleep pins against 2us glitches
// RULE6 - suspend request fall starts 200us delay
// RULE7 - after delay: soft-off request picks S5
// RULE8 - reset release starts first soft-start
// RULE9 - first ramp top: monitor, 3ms wait
// RULE10 - second ramp top: all monitors enabled
// RULE11 - 1.2V output only in active state
// RULE12 - active power-up waits 25ms after main
// RULE13 - standby rails start without the 25ms wait
// RULE14 - timer end: 1.2V start, gate release
// RULE15 - fault high on any undervoltage
// RULE16 - external pass undervoltage flags only
// RULE17 - on-chip pass undervoltage latches that rail
// RULE18 - soft-start held low: all off, clear
// RULE19 - early standby undervoltage latches whole chip
// RULE20 - 140C flags fault, 155C latches shutdown
// RULE21 - main loss while active forces S5
// RULE22 - forced S5 left by recovery, reset, SS
// RULE23 - 5V standby switch on in S3
// RULE24 - comparators synchronised, delays counted
module acpi_dual_rail_sequencer #(
    parameter bit VARIANT_A = 1'b0,
    parameter int DEGLITCH_CYC = `DEGLITCH_CYC,
    parameter int SLEEP_CYC = `SLEEP_DELAY_CYC,
    parameter int GAP_CYC = `GAP_CYC,
    parameter int WAKE_CYC = `WAKE_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic SLEEP_S3_N,
    input wire logic SLEEP_S5_N,
    input wire seq_pkg::uv_t UV_IN,
    input wire logic SS_TOP,
    input wire logic SS_SHUTDOWN,
    input wire logic TEMP_WARN,
    input wire logic TEMP_SHUTDOWN,
    output logic SS_RAMP_EN,
    output seq_pkg::rails_t RAILS,
    output logic STANDBY_3V3_PASS_DRIVE,
    output logic STANDBY_5V_SWITCH_DRIVE,
    output logic DUAL_SWITCH_GATE_RELEASE,
    output logic [4:0] UV_MON_EN,
    output logic FAULT,
    output seq_pkg::pstate_t PSTATE
);
    localparam int SW = $clog2(SLEEP_CYC + 1);
    localparam int GW = $clog2(GAP_CYC + 1);
    localparam int WW = $clog2(WAKE_CYC + 1);
    localparam int NS = 10;

    // sync of all asynchronous levels
    logic [NS-1:0] raw_a;
    logic [NS-1:0] raw_s;
    assign raw_a = {SLEEP_S3_N, SLEEP_S5_N, UV_IN, SS_TOP, SS_SHUTDOWN, TEMP_WARN};
    seq_sync #(.W(NS)) u_sync ( // RULE24
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .d(raw_a),
        .q(raw_s)
    );
    logic hot_s;
    seq_sync #(.W(1)) u_sync_hot (
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .d(TEMP_SHUTDOWN),
        .q(hot_s)
    );
    seq_pkg::uv_t uv;
    logic ss_top, ss_low, warm;
    assign uv = raw_s[7:3];
    assign ss_top = raw_s[2];
    assign ss_low = raw_s[1];
    assign warm = raw_s[0];

    logic s3_n, s5_n;
    seq_deglitch #(.CYC(DEGLITCH_CYC)) u_dg3 ( // RULE5
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .d(raw_s[9]),
        .q(s3_n)
    );
    seq_deglitch #(.CYC(DEGLITCH_CYC)) u_dg5 ( // RULE5
        .clk(CLK_SYS),
        .rst_n(RESETN),
        .d(raw_s[8]),
        .q(s5_n)
    );

    // strap of power-up pin state, caught after release
    logic boot_q, wake_pend_q;
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    // latches: whole-chip off and per-rail off
    logic chip_off_q, hot_off_q, early_q;
    logic [1:0] rail_off_q;
    seq_pkg::ss_t ss_q;
    seq_pkg::pstate_t st_q;
    logic forced_q;
    logic main_ok_q;
    assign early_q = (ss_q != seq_pkg::SS_DONE);
    // chip-wide latch armed until the first soft-start after bias reset completes
    logic first_ss_q;
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            first_ss_q <= 1'b1;
        end else if (ss_q == seq_pkg::SS_DONE) begin
            first_ss_q <= 1'b0;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            chip_off_q <= 1'b0;
            hot_off_q <= 1'b0;
        end else begin
            if (hot_s)
                hot_off_q <= 1'b1; // RULE20
            if (first_ss_q && early_q && ss_q != seq_pkg::SS_IDLE && !ss_low
                && ((uv.uv_dual_3v3_output && UV_MON_EN[4]) || (uv.uv_1v5 && UV_MON_EN[2])))
                chip_off_q <= 1'b1; // RULE19
        end
    end
    // on-chip regulators: 1.5V standby (bit0), 1.2V id (bit1)
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rail_off_q <= 2'h0;
        end else if (ss_low) begin
            rail_off_q <= 2'h0; // RULE18
        end else if (!early_q) begin
            if (uv.uv_1v5 && UV_MON_EN[2])
                rail_off_q[0] <= 1'b1; // RULE17
            if (uv.uv_1v2 && UV_MON_EN[1] && RAILS.id_1v2_on)
                rail_off_q[1] <= 1'b1; // RULE17
        end
    end

    // soft-start sequencer
    logic [GW-1:0] gap_q;
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ss_q <= seq_pkg::SS_IDLE;
            gap_q <= '0;
        end else if (ss_low || chip_off_q || hot_off_q) begin
            ss_q <= seq_pkg::SS_IDLE; // RULE18
            gap_q <= '0;
        end else begin
            case (ss_q)
                seq_pkg::SS_IDLE: ss_q <= seq_pkg::SS_RAMP1; // RULE8
                seq_pkg::SS_RAMP1: begin
                    if (ss_top) begin
                        ss_q <= seq_pkg::SS_GAP; // RULE9
                        gap_q <= '0;
                    end
                end
                seq_pkg::SS_GAP: begin
                    if (!ss_top && gap_q >= GW'(GAP_CYC - 1))
                        ss_q <= seq_pkg::SS_RAMP2; // RULE9
                    else if (gap_q < GW'(GAP_CYC - 1))
                        gap_q <= gap_q + 1'b1;
                end
                seq_pkg::SS_RAMP2: if (ss_top) ss_q <= seq_pkg::SS_DONE; // RULE10
                default: ss_q <= seq_pkg::SS_DONE; // RULE10
            endcase
        end
    end
    assign SS_RAMP_EN = (ss_q == seq_pkg::SS_RAMP1) || (ss_q == seq_pkg::SS_RAMP2);

    // monitor enables: {dual_3v3_output,dual_5v_output,1v5,1v2,main}
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            UV_MON_EN <= 5'h00;
        end else if (ss_q == seq_pkg::SS_IDLE) begin
            UV_MON_EN <= 5'h00;
        end else if (ss_q == seq_pkg::SS_GAP || ss_q == seq_pkg::SS_RAMP2) begin
            UV_MON_EN <= 5'h14; // RULE9
        end else if (ss_q == seq_pkg::SS_DONE) begin
            UV_MON_EN <= 5'h1F; // RULE10
        end
    end

    // main input good after 25ms; the wake timer gates active-only outputs
    logic [WW-1:0] wake_q;
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            wake_q <= '0;
            main_ok_q <= 1'b0;
        end else if (uv.uv_main || ss_low) begin
            wake_q <= '0;
            main_ok_q <= 1'b0;
        end else if (wake_q == WW'(WAKE_CYC - 1)) begin
            main_ok_q <= 1'b1; // RULE12
        end else begin
            wake_q <= wake_q + 1'b1;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            wake_pend_q <= 1'b0;
        end else if (boot_q) begin
            wake_pend_q <= s3_n && s5_n; // RULE12
        end else if (main_ok_q) begin
            wake_pend_q <= 1'b0;
        end
    end

    // power state machine
    logic [SW-1:0] dly_q;
    logic dly_run_q;
    logic s3_n_d1_q;
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            s3_n_d1_q <= 1'b1;
        end else begin
            s3_n_d1_q <= s3_n;
        end
    end
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            st_q <= seq_pkg::PW_ACTIVE;
            forced_q <= 1'b0;
            dly_q <= '0;
            dly_run_q <= 1'b0;
        end else if (ss_low) begin
            forced_q <= 1'b0; // RULE22
            dly_run_q <= 1'b0;
        end else if (st_q == seq_pkg::PW_ACTIVE && main_ok_q && uv.uv_main) begin
            st_q <= seq_pkg::PW_S5; // RULE21
            forced_q <= 1'b1;
            dly_run_q <= 1'b0;
        end else if (forced_q) begin
            if (!uv.uv_main)
                forced_q <= 1'b0; // RULE22
        end else begin
            case (st_q)
                seq_pkg::PW_ACTIVE: begin
                    if (s3_n_d1_q && !s3_n) begin
                        dly_run_q <= 1'b1; // RULE6
                        dly_q <= '0;
                    end else if (dly_run_q && s3_n) begin
                        dly_run_q <= 1'b0;
                    end else if (dly_run_q && dly_q == SW'(SLEEP_CYC - 1)) begin
                        dly_run_q <= 1'b0;
                        st_q <= s5_n ? seq_pkg::PW_S3 : seq_pkg::PW_S5; // RULE7
                    end else if (dly_run_q) begin
                        dly_q <= dly_q + 1'b1;
                    end
                end
                // sleep states only return to active, never to each other
                default: begin
                    if (s3_n && s5_n)
                        st_q <= seq_pkg::PW_ACTIVE; // RULE4
                    // forbidden pair (s5 low, s3 high) falls through: state kept
                    else
                        st_q <= st_q; // RULE3
                end
            endcase
        end
    end
    assign PSTATE = st_q;

    // outputs
    logic all_off, active_ok, in_s5;
    assign all_off = ss_low || chip_off_q || hot_off_q || ss_q == seq_pkg::SS_IDLE;
    assign active_ok = st_q == seq_pkg::PW_ACTIVE && !forced_q && !wake_pend_q && main_ok_q;
    assign in_s5 = st_q == seq_pkg::PW_S5;
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            RAILS <= '0;
            STANDBY_3V3_PASS_DRIVE <= 1'b0;
            STANDBY_5V_SWITCH_DRIVE <= 1'b0;
            DUAL_SWITCH_GATE_RELEASE <= 1'b0;
        end else if (all_off) begin
            RAILS <= '0; // RULE18
            STANDBY_3V3_PASS_DRIVE <= 1'b0;
            STANDBY_5V_SWITCH_DRIVE <= 1'b0;
            DUAL_SWITCH_GATE_RELEASE <= 1'b0;
        end else begin
            RAILS.dual_3v3_on <= 1'b1; // RULE13
            RAILS.standby_1v5_on <= !rail_off_q[0]; // RULE13
            RAILS.dual_5v_on <= !(in_s5 && !VARIANT_A) // RULE2
                && (active_ok || st_q != seq_pkg::PW_ACTIVE); // RULE1
            RAILS.id_1v2_on <= active_ok && !rail_off_q[1]; // RULE11 RULE14
            STANDBY_3V3_PASS_DRIVE <= !active_ok;
            STANDBY_5V_SWITCH_DRIVE <= st_q == seq_pkg::PW_S3 || (in_s5 && VARIANT_A); // RULE23
            DUAL_SWITCH_GATE_RELEASE <= active_ok; // RULE14
        end
    end

    // 1.2V and main monitors count only while those rails should be up
    seq_pkg::uv_t uv_live;
    always_comb begin
        uv_live = uv;
        uv_live.uv_1v2 = uv.uv_1v2 && RAILS.id_1v2_on;
        uv_live.uv_main = uv.uv_main && main_ok_q && st_q == seq_pkg::PW_ACTIVE;
    end
    // fault: any monitored undervoltage, heat, chip-off and forced-S5 latches; SS low forces it low
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            FAULT <= 1'b0;
        end else if (ss_low) begin
            FAULT <= 1'b0; // RULE18
        end else begin
            FAULT <= |(uv_live & UV_MON_EN) || warm || hot_s || hot_off_q
                || chip_off_q || forced_q; // RULE15 RULE16 RULE20
        end
    end

    AST_SSLOW_OFF: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        ss_low |=> (RAILS == '0) && !FAULT) // RULE18
        else $error("outputs not off with soft-start held low");
    AST_HOT: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        hot_off_q |=> RAILS == '0) // RULE20
        else $error("rails on after thermal shutdown");
    AST_ID_ACTIVE: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        RAILS.id_1v2_on |-> $past(st_q) == seq_pkg::PW_ACTIVE) // RULE11
        else $error("1.2V on outside active state");
    AST_NO_S3S5: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        st_q == seq_pkg::PW_S3 |=> st_q != seq_pkg::PW_S5) // RULE4
        else $error("direct S3 to S5 move");
    AST_NO_S5S3: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        st_q == seq_pkg::PW_S5 |=> st_q != seq_pkg::PW_S3) // RULE4
        else $error("direct S5 to S3 move");
    AST_GATE_ID: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $rose(DUAL_SWITCH_GATE_RELEASE) |-> active_ok || $past(active_ok)) // RULE14
        else $error("gate released outside active");
    AST_SLEEP_DLY: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $changed(st_q) && $past(st_q) == seq_pkg::PW_ACTIVE && !forced_q
        |-> $past(dly_run_q)) // RULE6
        else $error("sleep entered without delay");
    AST_S5_5V: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        in_s5 && !VARIANT_A && !all_off |=> !RAILS.dual_5v_on) // RULE2
        else $error("5V dual on in soft-off");
    AST_FORCED: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        forced_q && !ss_low |=> FAULT || ss_low) // RULE21
        else $error("forced S5 without fault");
    AST_RAIL_LATCH: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        rail_off_q[1] |=> !RAILS.id_1v2_on) // RULE17
        else $error("1.2V rail on while latched off");
    AST_WAKE_WAIT: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
        $rose(DUAL_SWITCH_GATE_RELEASE) |-> $past(main_ok_q)) // RULE12
        else $error("gate released before main input settled");
    COV_S3: cover property (@(posedge CLK_SYS) st_q == seq_pkg::PW_S3);
    COV_S5: cover property (@(posedge CLK_SYS) in_s5 && !forced_q);
    COV_WAKE: cover property (@(posedge CLK_SYS) $rose(DUAL_SWITCH_GATE_RELEASE));
    COV_DONE: cover property (@(posedge CLK_SYS) ss_q == seq_pkg::SS_DONE);
endmodule

/* hw/seq_cfg.svh */
// constants of the dual-rail sleep sequencer: timing and filter figures
// assumes a 100 MHz system clock
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH
`define CLK_PERIOD_NS 10
`define DEGLITCH_NS 2000
`define DEGLITCH_CYC ((`DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_DELAY_US 200
`define SLEEP_DELAY_CYC ((`SLEEP_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define GAP_MS 3
`define GAP_CYC ((`GAP_MS * 1000000) / `CLK_PERIOD_NS)
`define WAKE_MS 25
`define WAKE_CYC ((`WAKE_MS * 1000000) / `CLK_PERIOD_NS)
`endif

/* hw/seq_pkg.sv */
// types of the dual-rail sleep sequencer
// no assumptions beyond a SystemVerilog tool
package seq_pkg;
    typedef enum logic [1:0] {PW_ACTIVE, PW_S3, PW_S5} pstate_t;
    typedef enum logic [2:0] {SS_IDLE, SS_RAMP1, SS_GAP, SS_RAMP2, SS_DONE} ss_t;
    typedef struct packed {
        logic uv_dual_3v3_output;
        logic uv_dual_5v_output;
        logic uv_1v5;
        logic uv_1v2;
        logic uv_main;
    } uv_t;
    typedef struct packed {
        logic dual_3v3_on;
        logic dual_5v_on;
        logic standby_1v5_on;
        logic id_1v2_on;
    } rails_t;
endpackage

/* hw/seq_sync.sv */
// two-flop synchroniser for a bus of asynchronous comparator levels
// assumes levels stay stable for several clock periods
`timescale 1ns/100ps
module seq_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] m_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m_q <= '0;
            q <= '0;
        end else begin
            m_q <= d;
            q <= m_q;
        end
    end
endmodule

/* hw/seq_deglitch.sv */
// glitch filter: output follows input only after a stable run
// input already synchronised; pins idle high so reset value is high
`timescale 1ns/100ps
module seq_deglitch #(
    parameter int CYC = 200
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);
    logic [$clog2(CYC+1)-1:0] cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            q <= 1'b1;
        end else if (d == q) begin
            cnt_q <= '0;
        end else if (cnt_q == ($clog2(CYC+1))'(CYC - 1)) begin
            cnt_q <= '0;
            q <= d;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

/* tb/chipset_model.sv */
// model of the chipset that drives the two active-low sleep requests
// assumes a bench command: 0 active, 1 suspend, 2 soft-off, 3 forbidden pair
`timescale 1ns/100ps
module chipset_model (
    input wire logic clk,
    input wire logic [1:0] tgt,
    input wire logic glitch,
    output logic s3_n,
    output logic s5_n
);
    initial begin
        s3_n = 1'b1;
        s5_n = 1'b1;
    end
    // pins move just after an edge; glitch inverts the suspend pin briefly
    always @(posedge clk) begin
        s3_n <= ((tgt == 2'h0) || (tgt == 2'h3)) ^ glitch;
        // forbidden pair when the bench asks for it, or from a glitch during soft-off
        s5_n <= (tgt == 2'h0) || (tgt == 2'h1);
    end
endmodule

/* tb/test_acpi_dual_rail_sequencer.sv */
// self-checking bench of the dual-rail sleep sequencer
// assumes shortened timers; a second instance runs the 5V-kept-in-soft-off variant
`timescale 1ns/100ps
module test_acpi_dual_rail_sequencer;
    localparam int DG = 4, SL = 20, GP = 30, WK = 50;
    logic CLK_SYS = 1'b0, RESETN = 1'b0, ss_top = 1'b0, ss_shut = 1'b0;
    logic t_warn = 1'b0, t_shut = 1'b0, glitch = 1'b0, s3_n, s5_n;
    logic [1:0] tgt = 2'h0;
    seq_pkg::uv_t uv = 5'h01;
    logic ramp_en, pass3, sw5, gate, fault;
    logic [4:0] mon;
    seq_pkg::rails_t rails;
    seq_pkg::pstate_t pst;
    seq_pkg::rails_t rails_a;
    logic sw5_a;
    int err_total = 0, checks_done = 0;

    always #5 CLK_SYS = ~CLK_SYS;

    chipset_model PEER (.clk(CLK_SYS), .tgt(tgt), .glitch(glitch), .s3_n(s3_n), .s5_n(s5_n));
    acpi_dual_rail_sequencer #(.VARIANT_A(1'b0), .DEGLITCH_CYC(DG), .SLEEP_CYC(SL),
        .GAP_CYC(GP), .WAKE_CYC(WK)) DUT (
        .CLK_SYS(CLK_SYS), .RESETN(RESETN), .SLEEP_S3_N(s3_n), .SLEEP_S5_N(s5_n),
        .UV_IN(uv), .SS_TOP(ss_top), .SS_SHUTDOWN(ss_shut), .TEMP_WARN(t_warn),
        .TEMP_SHUTDOWN(t_shut), .SS_RAMP_EN(ramp_en), .RAILS(rails),
        .STANDBY_3V3_PASS_DRIVE(pass3), .STANDBY_5V_SWITCH_DRIVE(sw5),
        .DUAL_SWITCH_GATE_RELEASE(gate), .UV_MON_EN(mon), .FAULT(fault), .PSTATE(pst));
    acpi_dual_rail_sequencer #(.VARIANT_A(1'b1), .DEGLITCH_CYC(DG), .SLEEP_CYC(SL),
        .GAP_CYC(GP), .WAKE_CYC(WK)) DUT_A (
        .CLK_SYS(CLK_SYS), .RESETN(RESETN), .SLEEP_S3_N(s3_n), .SLEEP_S5_N(s5_n),
        .UV_IN(uv), .SS_TOP(ss_top), .SS_SHUTDOWN(ss_shut), .TEMP_WARN(t_warn),
        .TEMP_SHUTDOWN(t_shut), .SS_RAMP_EN(), .RAILS(rails_a),
        .STANDBY_3V3_PASS_DRIVE(), .STANDBY_5V_SWITCH_DRIVE(sw5_a),
        .DUAL_SWITCH_GATE_RELEASE(), .UV_MON_EN(), .FAULT(), .PSTATE());

    task automatic cyc(int k);
        repeat (k) @(posedge CLK_SYS);
    endtask
    task automatic fail(logic [7:0] g, logic [7:0] e);
        err_total++;
        $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e);
    endtask
    task automatic chk_b(logic g, logic e);
        checks_done++;
        if (g !== e) fail({7'h00, g}, {7'h00, e});
    endtask
    task automatic chk_v(logic [4:0] g, logic [4:0] e);
        checks_done++;
        if (g !== e) fail({3'h0, g}, {3'h0, e});
    endtask
    task automatic chk_st(seq_pkg::pstate_t g, seq_pkg::pstate_t e);
        checks_done++;
        if (g !== e) fail({6'h00, g}, {6'h00, e});
    endtask
    // bounded polls; n returns the cycles spent
    task automatic wait_o(logic g, logic v, int lim, output int n);
        n = 0;
        while ((g ? gate : ramp_en) !== v && n < lim) begin
            @(posedge CLK_SYS);
            #1;
            n++;
        end
    endtask
    task automatic wait_st(seq_pkg::pstate_t s, int lim);
        int n;
        n = 0;
        while (pst !== s && n < lim) begin
            @(posedge CLK_SYS);
            #1;
            n++;
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // early: break a standby rail inside the gap and stop there
    task automatic power_up(logic early);
        int n;
        wait_o(1'b0, 1'b1, 5, n);
        chk_b(ramp_en, 1'b1);
        cyc(1);
        #1;
        chk_b(rails.dual_3v3_on, 1'b1);
        cyc(1);
        ss_top <= 1'b1;
        wait_o(1'b0, 1'b0, 8, n);
        cyc(1);
        ss_top <= 1'b0;
        cyc(2);
        #1;
        chk_v(mon, 5'h14);
        if (early) begin
            cyc(1);
            uv.uv_dual_3v3_output <= 1'b1;
            cyc(6);
            #1;
            chk_b(fault, 1'b1);
            return;
        end
        wait_o(1'b0, 1'b1, GP + 8, n);
        chk_b(n >= GP - 8, 1'b1);
        cyc(1);
        ss_top <= 1'b1;
        wait_o(1'b0, 1'b0, 8, n);
        cyc(1);
        ss_top <= 1'b0;
        cyc(3);
        #1;
        chk_v(mon, 5'h1F);
        chk_b(gate | rails.id_1v2_on, 1'b0);
        cyc(1);
        uv.uv_main <= 1'b0;
        wait_o(1'b1, 1'b1, WK + 10, n);
        chk_b(n >= WK - 1, 1'b1);
        chk_v({1'b0, rails}, 5'h0F);
        chk_b(pass3, 1'b0);
    endtask

    task automatic go_sleep(logic [1:0] t);
        seq_pkg::pstate_t e;
        int n;
        e = (t == 2'h1) ? seq_pkg::PW_S3 : seq_pkg::PW_S5;
        cyc(1);
        tgt <= t;
        cyc(SL);
        #1;
        chk_st(pst, seq_pkg::PW_ACTIVE);
        wait_st(e, DG + 20);
        chk_st(pst, e);
        cyc(1);
        #1;
        chk_b(rails.dual_3v3_on, 1'b1);
        chk_b(rails.dual_5v_on, t == 2'h1);
        chk_b(rails_a.dual_5v_on, 1'b1);
        chk_b(rails.id_1v2_on, 1'b0);
        chk_b(pass3, 1'b1);
        chk_b(sw5, t == 2'h1);
        chk_b(sw5_a, 1'b1);
        cyc(1);
        glitch <= 1'b1;
        cyc(2);
        glitch <= 1'b0;
        cyc(8);
        #1;
        chk_st(pst, e);
        cyc(1);
        tgt <= (t == 2'h1) ? 2'h2 : 2'h3;
        cyc(DG + SL + 10);
        #1;
        chk_st(pst, e);
        cyc(1);
        tgt <= 2'h0;
        wait_st(seq_pkg::PW_ACTIVE, DG + 20);
        chk_st(pst, seq_pkg::PW_ACTIVE);
        wait_o(1'b1, 1'b1, WK + 20, n);
        chk_b(gate, 1'b1);
        cyc(1 + $urandom_range(15, 0));
    endtask

    initial begin
        void'($urandom(32'h18FF4B68));
        cyc(12);
        RESETN <= 1'b1;
        power_up(1'b1);
        cyc(1);
        uv <= 5'h00;
        cyc(5);
        #1;
        chk_v({1'b0, rails}, 5'h00);
        cyc(1);
        RESETN <= 1'b0;
        uv <= 5'h01;
        cyc(12);
        RESETN <= 1'b1;
        power_up(1'b0);
        $display("test power_up done");
        cyc(1);
        glitch <= 1'b1;
        cyc(2);
        glitch <= 1'b0;
        cyc(SL + 20);
        #1;
        chk_st(pst, seq_pkg::PW_ACTIVE);
        $display("test glitch done");
        for (int k = 0; k < 6; k++) begin
            go_sleep(k < 2 ? 2'(k + 1) : 2'($urandom_range(2, 1)));
        end
        $display("test sleep done");
        cyc(1);
        uv.uv_dual_5v_output <= 1'b1;
        cyc(6);
        #1;
        chk_b(fault, 1'b1);
        chk_v({1'b0, rails}, 5'h0F);
        cyc(1);
        uv.uv_dual_5v_output <= 1'b0;
        t_warn <= 1'b1;
        cyc(6);
        #1;
        chk_b(fault, 1'b1);
        chk_v({1'b0, rails}, 5'h0F);
        cyc(1);
        t_warn <= 1'b0;
        uv.uv_1v2 <= 1'b1;
        cyc(6);
        uv.uv_1v2 <= 1'b0;
        cyc(6);
        #1;
        chk_v({1'b0, rails}, 5'h0E);
        cyc(1);
        uv.uv_main <= 1'b1;
        wait_st(seq_pkg::PW_S5, 10);
        chk_st(pst, seq_pkg::PW_S5);
        chk_b(fault, 1'b1);
        cyc(1);
        uv.uv_main <= 1'b0;
        wait_st(seq_pkg::PW_ACTIVE, 10);
        chk_st(pst, seq_pkg::PW_ACTIVE);
        $display("test faults done");
        cyc(1);
        ss_shut <= 1'b1;
        cyc(6);
        #1;
        chk_v({fault, rails}, 5'h00);
        cyc(1);
        ss_shut <= 1'b0;
        cyc(20);
        t_shut <= 1'b1;
        cyc(6);
        t_shut <= 1'b0;
        cyc(20);
        #1;
        chk_v({1'b0, rails}, 5'h00);
        $display("test shutdown done");
        print_verdict();
    end

    initial begin
        cyc(30000);
        err_total++;
        print_verdict();
    end
endmodule
